// ==== pkg/cad_pkg.sv ====
// Package with operation classes, modes, conditions and address constants
package cad_pkg;
    localparam int ADDR_W = 16;
    localparam int DATA_W = 8;
    localparam logic [7:0] PAGE0_HIGH = 8'h00;
    localparam logic [15:0] PC_STEP_REL = 16'h0002;
    localparam logic [15:0] PC_STEP_BIT_BR = 16'h0003;
    localparam logic [15:0] PC_STEP_OTHER = 16'h0001;

    typedef enum logic [2:0] {
        CAD_MODE_INH, CAD_MODE_IMM, CAD_MODE_DIR, CAD_MODE_EXT,
        CAD_MODE_IDX0, CAD_MODE_IDX1, CAD_MODE_IDX2, CAD_MODE_REL
    } cad_mode_t;

    typedef enum logic [2:0] {
        CAD_CLS_REGMEM, CAD_CLS_RMW, CAD_CLS_BRANCH, CAD_CLS_BITBR,
        CAD_CLS_JUMP, CAD_CLS_BITMAN, CAD_CLS_CTRL
    } cad_class_t;

    // Read-modify-write operations
    typedef enum logic [3:0] {
        CAD_RMW_INC, CAD_RMW_DEC, CAD_RMW_CLR, CAD_RMW_COM, CAD_RMW_TWOS_COMP,
        CAD_RMW_ROT_LEFT, CAD_RMW_ROT_RIGHT, CAD_RMW_LOGIC_SHL, CAD_RMW_ARITH_SHL, CAD_RMW_LSR,
        CAD_RMW_ASR, CAD_RMW_TEST_NEG_ZERO
    } cad_rmw_t;

    // Register/memory operation subset relevant here
    typedef enum logic [1:0] {
        CAD_RM_LOAD_STORE_ALU, CAD_RM_PRODUCT
    } cad_rm_t;

    typedef enum logic [3:0] {
        CAD_BC_ALWAYS, CAD_BC_NEVER, CAD_BC_CARRY_CLR, CAD_BC_CARRY_SET,
        CAD_BC_NE, CAD_BC_EQ, CAD_BC_HC_CLR, CAD_BC_HC_SET, CAD_BC_HI,
        CAD_BC_LS, CAD_BC_PLUS, CAD_BC_MINUS, CAD_BC_MASK_CLR,
        CAD_BC_MASK_SET, CAD_BC_IRQ_LOW, CAD_BC_IRQ_HIGH
    } cad_cond_t;
endpackage

// ==== hw/cad_core.sv ====
// Address generation, branch resolution and operand execution for the CPU
`timescale 1ns/1ps
module cad_core (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic issue,
    input wire cad_pkg::cad_class_t op_class,
    input wire cad_pkg::cad_mode_t op_mode,
    input wire cad_pkg::cad_rmw_t rmw_op,
    input wire cad_pkg::cad_rm_t rm_op,
    input wire cad_pkg::cad_cond_t branch_cond,
    input wire logic branch_to_subroutine,
    input wire logic bit_test_value,
    input wire logic [7:0] byte1,
    input wire logic [7:0] byte2,
    input wire logic [15:0] pc,
    input wire logic [7:0] acc,
    input wire logic [7:0] index_reg,
    input wire logic [7:0] mem_rdata,
    input wire logic flag_c,
    input wire logic flag_z,
    input wire logic flag_n,
    input wire logic flag_h,
    input wire logic flag_i,
    input wire logic irq_pin,
    output logic [15:0] ea_reg,
    output logic [15:0] next_pc_reg,
    output logic taken_reg,
    output logic sub_call_reg,
    output logic illegal_reg,
    output logic wb_en_reg,
    output logic [7:0] wb_data_reg,
    output logic carry_out_reg,
    output logic [15:0] product_reg,
    output logic product_valid_reg,
    output logic done_reg
);
    import cad_pkg::*;

    logic irq_meta_reg;
    logic irq_sync_reg;
    logic [15:0] ea_next;
    logic [15:0] seq_pc;
    logic [15:0] rel_target;
    logic [15:0] wide_off;
    logic is_branch;
    logic cond_true;
    logic mode_ok;
    logic [7:0] rmw_src;
    logic [7:0] rmw_res;
    logic rmw_carry;
    logic [15:0] bit_dir_ea;

    // Effective address forms
    assign wide_off = {byte1, byte2};
    assign bit_dir_ea = (op_class == CAD_CLS_BITBR) ? {PAGE0_HIGH, byte1} : 16'h0000;
    always_comb begin
        case (op_mode)
            CAD_MODE_DIR: ea_next = {PAGE0_HIGH, byte1};
            CAD_MODE_EXT: ea_next = {byte1, byte2};
            CAD_MODE_IDX0: ea_next = {PAGE0_HIGH, index_reg};
            CAD_MODE_IDX1: ea_next = {7'h00, {1'b0, index_reg} + {1'b0, byte1}};
            CAD_MODE_IDX2: ea_next = wide_off + {8'h00, index_reg};
            CAD_MODE_REL: ea_next = bit_dir_ea;
            default: ea_next = 16'h0000;
        endcase
    end

    // Branch resolution
    assign is_branch = (op_class == CAD_CLS_BRANCH) || (op_class == CAD_CLS_BITBR);
    assign seq_pc = (op_class == CAD_CLS_BITBR) ? pc + PC_STEP_BIT_BR : pc + PC_STEP_REL;
    assign rel_target = seq_pc + {{8{(op_class == CAD_CLS_BITBR) ? byte2[7] : byte1[7]}},
                                  (op_class == CAD_CLS_BITBR) ? byte2 : byte1};

    always_comb begin
        if (op_class == CAD_CLS_BITBR) begin
            cond_true = bit_test_value;
        end else if (branch_to_subroutine) begin
            cond_true = 1'b1;
        end else begin
            case (branch_cond)
                CAD_BC_ALWAYS: cond_true = 1'b1;
                CAD_BC_NEVER: cond_true = 1'b0;
                CAD_BC_CARRY_CLR: cond_true = !flag_c;
                CAD_BC_CARRY_SET: cond_true = flag_c;
                CAD_BC_NE: cond_true = !flag_z;
                CAD_BC_EQ: cond_true = flag_z;
                CAD_BC_HC_CLR: cond_true = !flag_h;
                CAD_BC_HC_SET: cond_true = flag_h;
                CAD_BC_HI: cond_true = !(flag_c || flag_z);
                CAD_BC_LS: cond_true = flag_c || flag_z;
                CAD_BC_PLUS: cond_true = !flag_n;
                CAD_BC_MINUS: cond_true = flag_n;
                CAD_BC_MASK_CLR: cond_true = !flag_i;
                CAD_BC_MASK_SET: cond_true = flag_i;
                CAD_BC_IRQ_LOW: cond_true = !irq_sync_reg;
                CAD_BC_IRQ_HIGH: cond_true = irq_sync_reg;
                default: cond_true = 1'b0;
            endcase
        end
    end

    // Legal mode per class
    always_comb begin
        case (op_class)
            CAD_CLS_BRANCH: mode_ok = (op_mode == CAD_MODE_REL);
            CAD_CLS_BITBR: mode_ok = (op_mode == CAD_MODE_REL);
            CAD_CLS_REGMEM: begin
                if (rm_op == CAD_RM_PRODUCT) begin
                    mode_ok = (op_mode == CAD_MODE_INH);
                end else begin
                    mode_ok = (op_mode != CAD_MODE_REL) && (op_mode != CAD_MODE_INH);
                end
            end
            CAD_CLS_RMW: begin
                mode_ok = (op_mode == CAD_MODE_INH) || (op_mode == CAD_MODE_DIR) ||
                          (op_mode == CAD_MODE_IDX0) || (op_mode == CAD_MODE_IDX1);
            end
            CAD_CLS_JUMP: mode_ok = (op_mode == CAD_MODE_DIR) || (op_mode == CAD_MODE_EXT) ||
                                    (op_mode == CAD_MODE_IDX0) || (op_mode == CAD_MODE_IDX1) ||
                                    (op_mode == CAD_MODE_IDX2);
            CAD_CLS_BITMAN: mode_ok = (op_mode == CAD_MODE_DIR);
            CAD_CLS_CTRL: mode_ok = (op_mode == CAD_MODE_INH);
            default: mode_ok = 1'b0;
        endcase
    end

    // Read-modify-write datapath; inherent form works on the accumulator
    assign rmw_src = (op_mode == CAD_MODE_INH) ? acc : mem_rdata;
    always_comb begin
        rmw_carry = flag_c;
        case (rmw_op)
            CAD_RMW_INC: rmw_res = rmw_src + 8'h01;
            CAD_RMW_DEC: rmw_res = rmw_src - 8'h01;
            CAD_RMW_CLR: rmw_res = 8'h00;
            CAD_RMW_COM: rmw_res = ~rmw_src;
            CAD_RMW_TWOS_COMP: begin
                rmw_res = 8'h00 - rmw_src;
                rmw_carry = (rmw_src != 8'h00);
            end
            CAD_RMW_ROT_LEFT: begin
                rmw_res = {rmw_src[6:0], flag_c};
                rmw_carry = rmw_src[7];
            end
            CAD_RMW_ROT_RIGHT: begin
                rmw_res = {flag_c, rmw_src[7:1]};
                rmw_carry = rmw_src[0];
            end
            CAD_RMW_LOGIC_SHL, CAD_RMW_ARITH_SHL: begin
                rmw_res = {rmw_src[6:0], 1'b0};
                rmw_carry = rmw_src[7];
            end
            CAD_RMW_LSR: begin
                rmw_res = {1'b0, rmw_src[7:1]};
                rmw_carry = rmw_src[0];
            end
            CAD_RMW_ASR: begin
                rmw_res = {rmw_src[7], rmw_src[7:1]};
                rmw_carry = rmw_src[0];
            end
            CAD_RMW_TEST_NEG_ZERO: rmw_res = rmw_src;
            default: rmw_res = rmw_src;
        endcase
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            irq_meta_reg <= 1'b0;
            irq_sync_reg <= 1'b0;
        end else begin
            irq_meta_reg <= irq_pin;
            irq_sync_reg <= irq_meta_reg;
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            ea_reg <= 16'h0000;
            next_pc_reg <= 16'h0000;
            taken_reg <= 1'b0;
            sub_call_reg <= 1'b0;
            illegal_reg <= 1'b0;
            wb_en_reg <= 1'b0;
            wb_data_reg <= 8'h00;
            carry_out_reg <= 1'b0;
            product_reg <= 16'h0000;
            product_valid_reg <= 1'b0;
            done_reg <= 1'b0;
        end else begin
            done_reg <= issue;
            wb_en_reg <= 1'b0;
            taken_reg <= 1'b0;
            sub_call_reg <= 1'b0;
            product_valid_reg <= 1'b0;
            illegal_reg <= 1'b0;
            if (issue) begin
                illegal_reg <= !mode_ok;
                ea_reg <= ea_next;
                next_pc_reg <= is_branch ? seq_pc : pc + PC_STEP_OTHER;
                carry_out_reg <= flag_c;
                if (mode_ok && is_branch) begin
                    taken_reg <= cond_true;
                    sub_call_reg <= branch_to_subroutine && (op_class == CAD_CLS_BRANCH);
                    next_pc_reg <= cond_true ? rel_target : seq_pc;
                    if (op_class == CAD_CLS_BITBR) begin
                        carry_out_reg <= bit_test_value;
                    end
                end
                if (mode_ok && op_class == CAD_CLS_RMW) begin
                    wb_en_reg <= (rmw_op != CAD_RMW_TEST_NEG_ZERO);
                    wb_data_reg <= rmw_res;
                    carry_out_reg <= rmw_carry;
                end
                if (mode_ok && op_class == CAD_CLS_REGMEM && rm_op == CAD_RM_PRODUCT) begin
                    product_reg <= {8'h00, index_reg} * {8'h00, acc};
                    product_valid_reg <= 1'b1;
                end
            end
        end
    end

    AST_TEST_NO_WB: assert property (@(posedge core_clk) disable iff (rst)
        issue && op_class == CAD_CLS_RMW && rmw_op == CAD_RMW_TEST_NEG_ZERO |=> !wb_en_reg)
        else $error("test op wrote back");
    AST_RMW_MODE: assert property (@(posedge core_clk) disable iff (rst)
        issue && op_class == CAD_CLS_RMW && (op_mode == CAD_MODE_EXT || op_mode == CAD_MODE_IDX2)
        |=> illegal_reg && !wb_en_reg)
        else $error("rmw accepted wide mode");
    AST_REL_ONLY_BRANCH: assert property (@(posedge core_clk) disable iff (rst)
        issue && op_mode == CAD_MODE_REL && !is_branch |=> illegal_reg)
        else $error("relative mode accepted outside branch");
    AST_NOT_TAKEN: assert property (@(posedge core_clk) disable iff (rst)
        issue && op_class == CAD_CLS_BRANCH && op_mode == CAD_MODE_REL &&
        !branch_to_subroutine && branch_cond == CAD_BC_NEVER
        |=> !taken_reg && next_pc_reg == $past(pc) + 16'h0002)
        else $error("untaken branch went elsewhere");
    AST_TAKEN_TARGET: assert property (@(posedge core_clk) disable iff (rst)
        issue && op_class == CAD_CLS_BRANCH && op_mode == CAD_MODE_REL &&
        branch_cond == CAD_BC_ALWAYS
        |=> taken_reg &&
        next_pc_reg == $past(pc) + 16'h0002 + {{8{$past(byte1[7])}}, $past(byte1)})
        else $error("taken branch target wrong");
    AST_IDX0_ADDR: assert property (@(posedge core_clk) disable iff (rst)
        issue && op_mode == CAD_MODE_IDX0 |=> ea_reg == {8'h00, $past(index_reg)})
        else $error("indexed plain address wrong");
    AST_IDX1_ADDR: assert property (@(posedge core_clk) disable iff (rst)
        issue && op_mode == CAD_MODE_IDX1
        |=> ea_reg == {8'h00, $past(index_reg)} + {8'h00, $past(byte1)})
        else $error("indexed byte offset address wrong");
    AST_DIR_ADDR: assert property (@(posedge core_clk) disable iff (rst)
        issue && op_mode == CAD_MODE_DIR
        |=> ea_reg[15:8] == 8'h00 && ea_reg[7:0] == $past(byte1))
        else $error("direct address wrong");
    AST_BITBR_ADDR: assert property (@(posedge core_clk) disable iff (rst)
        issue && op_class == CAD_CLS_BITBR && op_mode == CAD_MODE_REL
        |=> ea_reg == {8'h00, $past(byte1)})
        else $error("bit test address wrong");
    AST_PRODUCT: assert property (@(posedge core_clk) disable iff (rst)
        issue && op_class == CAD_CLS_REGMEM && rm_op == CAD_RM_PRODUCT && op_mode == CAD_MODE_INH
        |=> product_valid_reg && product_reg == $past(index_reg) * $past(acc))
        else $error("product wrong");
    AST_SHIFT_SAME: assert property (@(posedge core_clk) disable iff (rst)
        issue && op_class == CAD_CLS_RMW && op_mode == CAD_MODE_INH &&
        (rmw_op == CAD_RMW_ARITH_SHL || rmw_op == CAD_RMW_LOGIC_SHL)
        |=> wb_data_reg == {$past(acc[6:0]), 1'b0} && carry_out_reg == $past(acc[7]))
        else $error("shift left wrong");
endmodule // cad_core

// ==== test/cad_core_tb.sv ====
// Self-checking testbench for the addressing and instruction class core
`timescale 1ns/1ps
module cad_core_tb;
    import cad_pkg::*;
    typedef struct {
        logic [15:0] ea;
        logic [15:0] npc;
        logic [15:0] prod;
        logic [7:0] wd;
        logic taken, sub, ill, wb_en, pv, carry;
        logic ea_chk, npc_chk, wd_chk, c_chk;
    } cad_exp_t;
    logic core_clk, rst, issue, branch_to_subroutine, bit_test_value, irq_pin;
    logic flag_c, flag_z, flag_n, flag_h, flag_i;
    cad_class_t op_class;
    cad_mode_t op_mode;
    cad_rmw_t rmw_op;
    cad_rm_t rm_op;
    cad_cond_t branch_cond;
    logic [7:0] byte1, byte2, acc, index_reg, mem_rdata, wb_data_reg;
    logic [15:0] pc, ea_reg, next_pc_reg, product_reg;
    logic taken_reg, sub_call_reg, illegal_reg, wb_en_reg, carry_out_reg;
    logic product_valid_reg, done_reg;
    int err_total, num_checks;
    integer seed = 32'ha4235625;
    cad_exp_t exp_q[$];
    cad_exp_t got;

    cad_core dut (.core_clk, .rst, .issue, .op_class, .op_mode, .rmw_op, .rm_op, .branch_cond,
        .branch_to_subroutine, .bit_test_value, .byte1, .byte2, .pc, .acc, .index_reg,
        .mem_rdata, .flag_c, .flag_z, .flag_n, .flag_h, .flag_i, .irq_pin, .ea_reg,
        .next_pc_reg, .taken_reg, .sub_call_reg, .illegal_reg, .wb_en_reg, .wb_data_reg,
        .carry_out_reg, .product_reg, .product_valid_reg, .done_reg);

    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end

    task automatic chk(input logic [15:0] seen, input logic [15:0] want);
        num_checks++;
        if (seen !== want) begin
            err_total++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, want);
        end
    endtask

    task automatic complete_run();
        if (err_total == 0 && num_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // Drive one instruction for one cycle and note what must come back
    task automatic run_op(input cad_class_t c, input cad_mode_t m, input int s, input logic b,
                          input int fix);
        cad_exp_t e;
        logic [7:0] x;
        logic [7:0] off;
        logic [15:0] cv;
        logic t;
        @(posedge core_clk);
        #1;
        op_class = c;
        op_mode = m;
        rmw_op = cad_rmw_t'(s % 12);
        rm_op = cad_rm_t'(s % 2);
        branch_cond = cad_cond_t'(s % 16);
        branch_to_subroutine = b;
        {byte1, byte2} = 16'($random(seed));
        pc = 16'($random(seed));
        {acc, index_reg, mem_rdata} = 24'($random(seed));
        {flag_c, flag_z, flag_n, flag_h, flag_i, bit_test_value} = 6'($random(seed));
        if (fix >= 0) begin
            byte1 = fix[7:0];
            pc = 16'hfff0;
        end
        issue = 1'b1;
        e = '{default: '0};
        x = (m == CAD_MODE_INH) ? acc : mem_rdata;
        case (m)
            CAD_MODE_EXT: e.ea = {byte1, byte2};
            CAD_MODE_IDX0: e.ea = {8'h00, index_reg};
            CAD_MODE_IDX1: e.ea = {8'h00, index_reg} + {8'h00, byte1};
            CAD_MODE_IDX2: e.ea = {byte1, byte2} + {8'h00, index_reg};
            default: e.ea = {8'h00, byte1};
        endcase
        e.ea_chk = (m inside {[CAD_MODE_DIR:CAD_MODE_IDX2]});
        e.ea_chk = e.ea_chk || (c == CAD_CLS_BITBR && m == CAD_MODE_REL);
        cv = {irq_pin, !irq_pin, flag_i, !flag_i, flag_n, !flag_n, flag_c | flag_z,
              !(flag_c | flag_z), flag_h, !flag_h, flag_z, !flag_z, flag_c, !flag_c, 2'b01};
        case (c)
            CAD_CLS_BRANCH, CAD_CLS_BITBR: begin
                e.ill = (m != CAD_MODE_REL);
                t = (c == CAD_CLS_BITBR) ? bit_test_value : (cv[branch_cond] | b);
                e.taken = t & !e.ill;
                e.sub = b & (c == CAD_CLS_BRANCH) & !e.ill;
                off = (c == CAD_CLS_BITBR) ? byte2 : byte1;
                e.npc = pc + ((c == CAD_CLS_BITBR) ? PC_STEP_BIT_BR : PC_STEP_REL)
                    + (t ? {{8{off[7]}}, off} : 16'h0000);
                e.npc_chk = !e.ill;
                e.carry = bit_test_value;
                e.c_chk = !e.ill && c == CAD_CLS_BITBR;
            end
            CAD_CLS_RMW: begin
                e.ill = !(m inside {CAD_MODE_INH, CAD_MODE_DIR, CAD_MODE_IDX0, CAD_MODE_IDX1});
                e.wb_en = !e.ill && rmw_op != CAD_RMW_TEST_NEG_ZERO;
                e.wd_chk = e.wb_en;
                e.c_chk = !e.ill;
                e.carry = flag_c;
                case (rmw_op)
                    CAD_RMW_INC: e.wd = x + 8'h01;
                    CAD_RMW_DEC: e.wd = x - 8'h01;
                    CAD_RMW_CLR: e.wd = 8'h00;
                    CAD_RMW_COM: e.wd = ~x;
                    CAD_RMW_TWOS_COMP: {e.carry, e.wd} = {x != 8'h00, 8'h00 - x};
                    CAD_RMW_ROT_LEFT: {e.carry, e.wd} = {x, flag_c};
                    CAD_RMW_ROT_RIGHT: {e.wd, e.carry} = {flag_c, x};
                    CAD_RMW_LOGIC_SHL, CAD_RMW_ARITH_SHL: {e.carry, e.wd} = {x, 1'b0};
                    CAD_RMW_LSR: {e.wd, e.carry} = {1'b0, x};
                    CAD_RMW_ASR: {e.wd, e.carry} = {x[7], x};
                    default: e.wd = x;
                endcase
            end
            CAD_CLS_REGMEM: begin
                e.ill = (rm_op == CAD_RM_PRODUCT) ? (m != CAD_MODE_INH)
                    : !(m inside {[CAD_MODE_IMM:CAD_MODE_IDX2]});
                e.pv = !e.ill && rm_op == CAD_RM_PRODUCT;
                e.prod = {8'h00, index_reg} * {8'h00, acc};
            end
            CAD_CLS_JUMP: e.ill = !(m inside {[CAD_MODE_DIR:CAD_MODE_IDX2]});
            CAD_CLS_BITMAN: e.ill = (m != CAD_MODE_DIR);
            CAD_CLS_CTRL: e.ill = (m != CAD_MODE_INH);
            default: e.ill = 1'b1;
        endcase
        exp_q.push_back(e);
    endtask

    task automatic idle(input int n);
        repeat (n) begin
            @(posedge core_clk);
            #1;
            issue = 1'b0;
        end
    endtask

    always @(posedge core_clk) begin
        #2;
        if (done_reg === 1'b1) begin
            if (exp_q.size() == 0) begin
                chk(16'h0001, 16'h0000);
            end else begin
                got = exp_q.pop_front();
                chk(16'(taken_reg), 16'(got.taken));
                chk(16'(sub_call_reg), 16'(got.sub));
                chk(16'(illegal_reg), 16'(got.ill));
                chk(16'(wb_en_reg), 16'(got.wb_en));
                chk(16'(product_valid_reg), 16'(got.pv));
                if (got.ea_chk) chk(ea_reg, got.ea);
                if (got.npc_chk) chk(next_pc_reg, got.npc);
                if (got.wd_chk) chk(16'(wb_data_reg), 16'(got.wd));
                if (got.c_chk) chk(16'(carry_out_reg), 16'(got.carry));
                if (got.pv) chk(product_reg, got.prod);
            end
        end
    end

    initial begin
        #100000;
        err_total++;
        complete_run();
    end

    initial begin
        {rst, issue, branch_to_subroutine, bit_test_value, irq_pin} = 5'h10;
        {flag_c, flag_z, flag_n, flag_h, flag_i} = 5'h00;
        op_class = CAD_CLS_REGMEM;
        op_mode = CAD_MODE_INH;
        rmw_op = CAD_RMW_INC;
        rm_op = CAD_RM_LOAD_STORE_ALU;
        branch_cond = CAD_BC_ALWAYS;
        {byte1, byte2, acc, index_reg, mem_rdata, pc} = '0;
        repeat (16) @(posedge core_clk);
        chk(16'({taken_reg, illegal_reg, wb_en_reg, done_reg, product_valid_reg}), 16'h0000);
        #1;
        rst = 1'b0;
        for (int p = 0; p < 2; p++) begin
            irq_pin = p[0];
            idle(4);
            for (int k = 0; k < 16; k++)
                for (int b = 0; b < 2; b++) run_op(CAD_CLS_BRANCH, CAD_MODE_REL, k, b[0], -1);
        end
        run_op(CAD_CLS_BRANCH, CAD_MODE_REL, 0, 1'b0, 8'h7f);
        run_op(CAD_CLS_BRANCH, CAD_MODE_REL, 0, 1'b0, 8'h80);
        run_op(CAD_CLS_JUMP, CAD_MODE_REL, 0, 1'b0, -1);
        for (int c = 0; c < 7; c++)
            for (int m = 0; m < 8; m++)
                for (int s = 0; s < 12; s++) begin
                    run_op(cad_class_t'(c), cad_mode_t'(m), s, 1'b0, -1);
                end
        idle(4);
        chk(16'(exp_q.size()), 16'h0000);
        complete_run();
    end
endmodule // cad_core_tb
